// >>> src/acl_pkg.sv
// Package for the audio configuration and link status register pair
package acl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ACL_ADDR_AUDIO_CFG = 8'h55;
  localparam logic [7:0] ACL_ADDR_LINK_STS = 8'h5a;
  localparam logic [7:0] ACL_AUDIO_CFG_RESET = 8'h0c;
  localparam logic [7:0] ACL_LINK_STS_RESET = 8'h00;
  localparam logic [7:0] ACL_AUDIO_CFG_MASK = 8'hcf;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ACL_BIT_TDM_TO_PARALLEL = 7;
  localparam int ACL_BIT_AUDIO_MIRROR = 6;
  localparam int ACL_BIT_RST_ON_TYPE = 3;
  localparam int ACL_BIT_RESET_ON_AUDIO_IF = 2;
  localparam int ACL_BIT_RESET_ON_VIDEO_IF = 1;
  localparam int ACL_BIT_RESET_ON_CLK_REGEN = 0;

  localparam int ACL_STS_LINK_READY = 7;
  localparam int ACL_STS_TX_LOCKED = 6;
  localparam int ACL_STS_PORT_MSB = 5;
  localparam int ACL_STS_PORT_LSB = 4;
  localparam int ACL_STS_INPUT_VALID = 3;
  localparam int ACL_STS_PLL_LOCK = 2;
  localparam int ACL_STS_NO_CLOCK = 1;
  localparam int ACL_STS_FREQ_SETTLED = 0;

  localparam logic [7:0] ACL_UNMAPPED_RDATA = 8'h00;

  localparam logic [1:0] ACL_SRC_INPUT_LINK_ONLY = 2'h0;
  localparam logic [1:0] ACL_PORT_DUAL = 2'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acl_req_type;

  typedef struct packed {
    logic link_ready;
    logic tx_active;
    logic rx_locked;
    logic mode_entered;
    logic [1:0] port_mode;
    logic data_valid;
    logic pll_lock;
    logic no_clock;
    logic freq_settled;
  } acl_status_type;

  typedef struct packed {
    logic type_changed;
    logic aif_changed;
    logic avi_changed;
    logic acr_changed;
  } acl_event_type;

endpackage

// >>> src/acl_fifo_reset_ctl.sv
// Audio FIFO reset request from received-stream change events
`timescale 1ns/100ps
`default_nettype none
module acl_fifo_reset_ctl (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [3:0] enable_mask,
  input wire acl_pkg::acl_event_type events,
  output logic fifo_reset
);
  import acl_pkg::*;

  logic fifo_reset_reg;
  logic fifo_reset_next;

  // ----------------------------------------------------------------
  // Gate each change event by its enable bit
  // ----------------------------------------------------------------
  always_comb begin
    fifo_reset_next = (events.type_changed & enable_mask[ACL_BIT_RST_ON_TYPE]) |
                      (events.aif_changed & enable_mask[ACL_BIT_RESET_ON_AUDIO_IF]) |
                      (events.avi_changed & enable_mask[ACL_BIT_RESET_ON_VIDEO_IF]) |
                      (events.acr_changed & enable_mask[ACL_BIT_RESET_ON_CLK_REGEN]);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fifo_reset_reg <= 1'b0;
    end else begin
      fifo_reset_reg <= fifo_reset_next;
    end
  end

  assign fifo_reset = fifo_reset_reg;

endmodule // acl_fifo_reset_ctl
`default_nettype wire

// >>> src/acl_regs.sv
// Audio configuration and link status registers with their control effects
//
// Summary of operation
// - Conversion bit enables converter and its clock
// - Mirror input audio only in source mode 00
// - Type change resets audio FIFO when enabled
// - Audio infoframe checksum change resets FIFO
// - Video infoframe checksum change resets FIFO
// - Clock regen N/CTS change resets FIFO
// - Link ready after downstream detect and capabilities
// - Tx status needs active, locked, valid, mode
// - Port mode field reported while tx status set
// - Input valid while recovering data; A1 reads one
// - PLL lock bit follows input PLL lock
// - No-clock bit when frequency below threshold
// - Frequency stable bit from frequency detector
`timescale 1ns/100ps
`default_nettype none
module acl_regs #(
  parameter bit EARLY_REV = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire acl_pkg::acl_req_type req,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire logic [1:0] audio_source_mode,
  input wire acl_pkg::acl_status_type status_in,
  input wire acl_pkg::acl_event_type events,
  output logic conv_enable,
  output logic audio_tx_clk_sel,
  output logic audio_mirror_enable,
  output logic audio_fifo_reset
);
  import acl_pkg::*;

  logic [7:0] audio_cfg_reg;
  logic [7:0] audio_cfg_next;
  acl_status_type st_meta_reg;
  acl_status_type st_sync_reg;
  acl_event_type ev_meta_reg;
  acl_event_type ev_sync_reg;
  acl_event_type ev_prev_reg;
  acl_event_type ev_pulse;
  logic [7:0] link_sts;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic conv_enable_reg;
  logic mirror_reg;
  logic cfg_write;
  logic cfg_read;
  logic sts_read;
  logic tx_status;
  logic [1:0] port_field;
  logic input_valid;
  logic mirror_mode_ok;

  // ----------------------------------------------------------------
  // Address decode shared by the write and read paths
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input acl_req_type r, input logic [7:0] a);
    return r.addr == a;
  endfunction

  // ----------------------------------------------------------------
  // Synchronisers for status levels and change toggles
  // ----------------------------------------------------------------
  // Status levels come from other clock domains: two stages first
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_meta_reg <= '0;
      st_sync_reg <= '0;
    end else begin
      st_meta_reg <= status_in;
      st_sync_reg <= st_meta_reg;
    end
  end

  // Change events arrive as toggles from the receive domain
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ev_meta_reg <= '0;
      ev_sync_reg <= '0;
      ev_prev_reg <= '0;
    end else begin
      ev_meta_reg <= events;
      ev_sync_reg <= ev_meta_reg;
      ev_prev_reg <= ev_sync_reg;
    end
  end

  assign ev_pulse = ev_sync_reg ^ ev_prev_reg;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // A write to the status address decodes to nothing and is dropped
  assign cfg_write = req.write & addr_hit(req, ACL_ADDR_AUDIO_CFG);
  assign cfg_read = req.read & addr_hit(req, ACL_ADDR_AUDIO_CFG);
  assign sts_read = req.read & addr_hit(req, ACL_ADDR_LINK_STS);

  // ----------------------------------------------------------------
  // Audio configuration register
  // ----------------------------------------------------------------
  // Reserved bits are masked so they always read back as zero
  always_comb begin
    audio_cfg_next = audio_cfg_reg;
    if (cfg_write) begin
      audio_cfg_next = req.wdata & ACL_AUDIO_CFG_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      audio_cfg_reg <= ACL_AUDIO_CFG_RESET;
    end else begin
      audio_cfg_reg <= audio_cfg_next;
    end
  end

  // ----------------------------------------------------------------
  // Link status composition
  // ----------------------------------------------------------------
  // Transmit status needs active, locked, valid and mode entered at once
  always_comb begin
    tx_status = st_sync_reg.tx_active & st_sync_reg.rx_locked &
                st_sync_reg.data_valid & st_sync_reg.mode_entered;
  end

  always_comb begin
    port_field = ACL_PORT_DUAL;
    if (tx_status) begin
      port_field = st_sync_reg.port_mode;
    end
  end

  // Early silicon reports the input as valid whatever the receiver sees
  always_comb begin
    input_valid = st_sync_reg.data_valid;
    if (EARLY_REV) begin
      input_valid = 1'b1;
    end
  end

  always_comb begin
    link_sts = ACL_LINK_STS_RESET;
    link_sts[ACL_STS_LINK_READY] = st_sync_reg.link_ready;
    link_sts[ACL_STS_TX_LOCKED] = tx_status;
    link_sts[ACL_STS_PORT_MSB:ACL_STS_PORT_LSB] = port_field;
    link_sts[ACL_STS_INPUT_VALID] = input_valid;
    link_sts[ACL_STS_PLL_LOCK] = st_sync_reg.pll_lock;
    link_sts[ACL_STS_NO_CLOCK] = st_sync_reg.no_clock;
    link_sts[ACL_STS_FREQ_SETTLED] = st_sync_reg.freq_settled;
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // One-cycle answer strobe for every read, mapped or not
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= req.read;
    end
  end

  // Read data holds between reads so a slow host may fetch it late
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata_reg <= '0;
    end else if (cfg_read) begin
      rdata_reg <= audio_cfg_reg;
    end else if (sts_read) begin
      rdata_reg <= link_sts;
    end else if (req.read) begin
      rdata_reg <= ACL_UNMAPPED_RDATA;
    end
  end

  assign rdata = rdata_reg;
  assign rvalid = rvalid_reg;

  // ----------------------------------------------------------------
  // Audio path controls
  // ----------------------------------------------------------------
  // Source mode is driven from this clock domain and needs no stages
  assign mirror_mode_ok = (audio_source_mode == ACL_SRC_INPUT_LINK_ONLY);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      conv_enable_reg <= 1'b0;
    end else begin
      conv_enable_reg <= audio_cfg_reg[ACL_BIT_TDM_TO_PARALLEL];
    end
  end

  // Mirror bit is ignored outside the input-link-only source mode
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mirror_reg <= 1'b0;
    end else begin
      mirror_reg <= audio_cfg_reg[ACL_BIT_AUDIO_MIRROR] & mirror_mode_ok;
    end
  end

  assign conv_enable = conv_enable_reg;
  assign audio_mirror_enable = mirror_reg;
  // Select line for the downstream audio clock mux outside this block
  assign audio_tx_clk_sel = conv_enable_reg;

  acl_fifo_reset_ctl u_fifo_reset (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .enable_mask(audio_cfg_reg[ACL_BIT_RST_ON_TYPE:ACL_BIT_RESET_ON_CLK_REGEN]),
    .events(ev_pulse),
    .fifo_reset(audio_fifo_reset)
  );

endmodule // acl_regs
`default_nettype wire

// >>> dv/acl_regs_sva.sv
// Checker for the audio configuration and link status registers
`timescale 1ns/100ps
`default_nettype none
module acl_regs_chk (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire acl_pkg::acl_req_type req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic [1:0] audio_source_mode,
  input wire acl_pkg::acl_event_type events,
  input wire logic conv_enable,
  input wire logic audio_tx_clk_sel,
  input wire logic audio_mirror_enable,
  input wire logic audio_fifo_reset
);
  import acl_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic [7:0] cfg_model;
  logic [3:0] ev_seen;
  logic [3:0] ev_flip;
  // Mirror of the configuration register and last seen event toggles
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cfg_model <= ACL_AUDIO_CFG_RESET;
      ev_seen <= '0;
    end else begin
      if (req.write && req.addr == ACL_ADDR_AUDIO_CFG) begin
        cfg_model <= req.wdata & ACL_AUDIO_CFG_MASK;
      end
      ev_seen <= events;
    end
  end
  assign ev_flip = events ^ ev_seen;
  sequence s_event_armed;
    (ev_flip != 4'h0) ##2 (($past(ev_flip, 2) & cfg_model[3:0]) != 4'h0);
  endsequence
  sequence s_cfg_ans;
    rvalid && $past(req.addr) == ACL_ADDR_AUDIO_CFG;
  endsequence
  sequence s_sts_idle;
    rvalid && $past(req.addr) == ACL_ADDR_LINK_STS && !rdata[6];
  endsequence
  a_read_answer: assert property (req.read |=> rvalid) else $error("read unanswered");
  a_answer_cause: assert property (rvalid |-> $past(req.read)) else $error("stray answer");
  a_rdata_hold: assert property (!rvalid |-> $stable(rdata)) else $error("rdata moved");
  a_clk_sel: assert property (req.write && req.addr == ACL_ADDR_AUDIO_CFG |->
    ##2 audio_tx_clk_sel == $past(req.wdata[ACL_BIT_TDM_TO_PARALLEL], 2)) else $error("clk sel");
  a_conv_write: assert property (req.write && req.addr == ACL_ADDR_AUDIO_CFG |->
    ##2 conv_enable == $past(req.wdata[ACL_BIT_TDM_TO_PARALLEL], 2)) else $error("conv enable");
  a_mirror_mode: assert property (audio_mirror_enable |->
    $past(audio_source_mode) == ACL_SRC_INPUT_LINK_ONLY) else $error("mirror mode");
  a_cfg_reserved: assert property (s_cfg_ans |-> rdata[5:4] == 2'h0) else $error("rsvd");
  a_port_idle: assert property (s_sts_idle |-> rdata[5:4] == ACL_PORT_DUAL) else $error("port");
  a_fifo_cause: assert property (audio_fifo_reset |->
    ($past(ev_flip, 3) & $past(cfg_model[3:0], 1)) != 4'h0) else $error("fifo cause");
  a_fifo_event: assert property (s_event_armed |=> audio_fifo_reset) else $error("fifo event");
endmodule // acl_regs_chk
bind acl_regs acl_regs_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .req(req),
  .rdata(rdata), .rvalid(rvalid), .audio_source_mode(audio_source_mode), .events(events),
  .conv_enable(conv_enable), .audio_tx_clk_sel(audio_tx_clk_sel),
  .audio_mirror_enable(audio_mirror_enable), .audio_fifo_reset(audio_fifo_reset));
`default_nettype wire

// >>> dv/acl_host.sv
// Host controller model issuing single register cycles
`timescale 1ns/100ps
`default_nettype none
module acl_host (
  input wire logic clk_sys,
  output var acl_pkg::acl_req_type req
);
  import acl_pkg::*;
  initial req = '0;
  // Idle bus shows the inverse of the last address and data
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req <= {w, ~w, a, d};
    @(negedge clk_sys);
    req <= {2'b00, ~a, ~d};
  endtask
endmodule // acl_host
`default_nettype wire

// >>> dv/tb.sv
// Testbench for the audio configuration and link status registers
`timescale 1ns/100ps
`default_nettype none
module tb;
  import acl_pkg::*;
  logic clk_sys = 0, rst_b = 0, rvalid, conv, csel, mir, frst;
  logic [7:0] rdata, e, x;
  logic [1:0] mode = 0;
  acl_req_type req;
  acl_status_type st = '0;
  acl_event_type ev = '0;
  logic [7:0] q[$];
  int num_errors = 0, comparisons = 0, seed = 99, pulses = 0, k, n;
  always #5 clk_sys = ~clk_sys;
  acl_host u_host (.clk_sys(clk_sys), .req(req));
  acl_regs u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .req(req), .rdata(rdata),
    .rvalid(rvalid), .audio_source_mode(mode), .status_in(st), .events(ev),
    .conv_enable(conv),
    .audio_tx_clk_sel(csel), .audio_mirror_enable(mir), .audio_fifo_reset(frst));
  task automatic chk(input string s, input logic [7:0] a, input logic [7:0] b);
    comparisons++;
    if (a !== b) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", s, a, b);
    end
  endtask
  always @(negedge clk_sys) begin
    if (frst === 1'b1) pulses <= pulses + 1;
    if (rvalid === 1'b1) chk("rdata", q.size() > 0 ? q.pop_front() : ~rdata, rdata);
  end
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    q.push_back(v);
    u_host.xfer(1'b0, a, 8'h00);
  endtask
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    end_of_test;
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    rst_b = 1;
    rd(ACL_ADDR_AUDIO_CFG, ACL_AUDIO_CFG_RESET);
    rd(ACL_ADDR_LINK_STS, ACL_LINK_STS_RESET);
    rd(8'h3c, 8'h00);
    for (n = 0; n < 8; n++) begin
      e = 8'($random(seed));
      mode = n[1:0];
      u_host.xfer(1'b1, ACL_ADDR_AUDIO_CFG, e);
      repeat (2) @(negedge clk_sys);
      chk("conv", 8'(e[7]), 8'(conv));
      chk("csel", 8'(e[7]), 8'(csel));
      chk("mirror", 8'(e[6] & (mode == 2'h0)), 8'(mir));
      rd(ACL_ADDR_AUDIO_CFG, e & ACL_AUDIO_CFG_MASK);
      st = acl_status_type'(10'($random(seed)));
      repeat (4) @(negedge clk_sys);
      k = st.tx_active & st.rx_locked & st.data_valid & st.mode_entered;
      x = {st.link_ready, k[0], k[0] ? st.port_mode : 2'h0, st.data_valid,
        st.pll_lock, st.no_clock, st.freq_settled};
      rd(ACL_ADDR_LINK_STS, x);
      u_host.xfer(1'b1, ACL_ADDR_LINK_STS, ~x);
      rd(ACL_ADDR_LINK_STS, x);
    end
    for (n = 0; n < 4; n++) begin
      u_host.xfer(1'b1, ACL_ADDR_AUDIO_CFG, 8'h01 << n);
      k = pulses;
      ev[n] = ~ev[n];
      repeat (8) @(negedge clk_sys);
      ev[(n + 1) % 4] = ~ev[(n + 1) % 4];
      repeat (8) @(negedge clk_sys);
      chk("fifo_reset", 8'(k + 1), 8'(pulses));
    end
    end_of_test;
  end
endmodule // tb
`default_nettype wire
